// >>> rtl/boot_command_loader.sv
// boot command interpreter behind the byte-wide register port
`timescale 1ns/1ps
`default_nettype none
`include "boot_loader_regs.svh"

module boot_command_loader
	import boot_loader_pkg::*;
#(
	// ram placement; the size only bounds the pointer and write checks
	parameter logic [31:0] RAM_BASE  = 32'h2000_0000,
	parameter logic [16:0] RAM_BYTES = 17'h0_4000
) (
	input  wire logic    mclk,
	input  wire logic    arst_n,
	// register port from the serial slave, one byte per access
	input  wire reg_req_type req,
	output logic [7:0]   rdata,
	// requests to the system around the core
	output logic         core_reset,
	output logic         ram_remap,
	output logic         download_init,
	output logic         power_on,
	// RAM write path
	output logic         ram_wr_valid,
	output ram_write_type ram_wr,
	input  wire logic    ram_wr_ready
);

	state_type   state_reg;
	state_type   state_next;
	logic [7:0]  command_status_reg;
	logic [7:0]  payload_length_reg;
	logic [7:0]  frame_checksum_reg;
	logic [7:0]  data_mem [0:127];
	logic [7:0]  idx_reg;
	logic [7:0]  sum_reg;
	logic [15:0] ptr_reg;
	logic        remap_reg;
	logic        core_reset_reg;
	logic        download_init_reg;
	logic        pon_reg;
	logic [7:0]  rdata_reg;
	logic        buf_in_ready;
	logic        buf_out_valid;
	ram_write_type buf_out_data;

	// frame map: command at 0x08, length at 0x09, data from 0x0a on;
	// the checksum slot follows the last data byte, so a frame of n data
	// bytes ends at 0x0a+n and any earlier write there is only a data byte.
	// the frame registers ignore host writes until the running command ends,
	// which keeps a late host write from racing the status update
	// frame address decode; the checksum slot moves with the length byte
	wire logic       idle       = (state_reg == ST_IDLE);
	wire logic [7:0] frame_checksum_pos   = `OFS_PAYLOAD_BYTE + payload_length_reg;
	wire logic [7:0] data_off   = req.addr - `OFS_PAYLOAD_BYTE;
	wire logic       in_data    = (req.addr >= `OFS_PAYLOAD_BYTE) && (data_off < `MAX_PAYLOAD);
	wire logic       frame_wr   = req.wr && idle;  // frame is frozen while a command runs
	wire logic       trigger    = frame_wr && (req.addr == frame_checksum_pos);
	wire logic       data_wr    = frame_wr && in_data;
	wire logic       wr_cmd     = frame_wr && (req.addr == `OFS_COMMAND_STATUS);
	wire logic       wr_len     = frame_wr && (req.addr == `OFS_PAYLOAD_LENGTH);
	wire logic       wr_pwr     = req.wr && (req.addr == `OFS_POWER_STATE);

	// command decode
	// the byte still holds the host's code until the command finishes
	wire logic is_sys_reset = (command_status_reg == `CMD_SYS_RESET);
	wire logic is_ram_map   = (command_status_reg == `CMD_RAM_MAP_REBOOT);
	wire logic is_rom_map   = (command_status_reg == `CMD_ROM_MAP_REBOOT);
	wire logic is_reset     = is_sys_reset || is_ram_map || is_rom_map;
	wire logic is_dl_init   = (command_status_reg == `CMD_DOWNLOAD_INIT);
	wire logic is_ram_write = (command_status_reg == `CMD_RAM_WRITE);
	wire logic is_ptr_set   = (command_status_reg == `CMD_POINTER_SET);
	// codes below 0x10 and undefined codes fall out here as unsupported
	wire logic known_cmd    = is_reset || is_dl_init || is_ram_write || is_ptr_set;

	// length check per command
	// a reset-type code must carry no payload at all
	wire logic size_ok =
		is_reset     ? (payload_length_reg == 8'h00) :
		is_dl_init   ? (payload_length_reg == `SIZE_DL_INIT) :
		is_ptr_set   ? (payload_length_reg == `SIZE_POINTER) :
		is_ram_write ? (payload_length_reg <= `MAX_PAYLOAD) :
		1'b1;

	// checksum walk over the stored data bytes
	// one byte per cycle keeps the adder narrow at the cost of latency
	wire logic [7:0] cur_byte = data_mem[idx_reg[6:0]];
	wire logic       walk_end = (idx_reg == payload_length_reg);
	wire logic [7:0] sum_next = sum_reg + cur_byte;
	wire logic       frame_checksum_ok  = ((sum_reg ^ `CHECKSUM_INVERT) == frame_checksum_reg);

	// pointer and range checks; offsets are relative to the RAM base
	// a write may end exactly at the top of RAM; a pointer may not sit there
	wire logic [15:0] new_off   = {data_mem[1], data_mem[0]};
	wire logic        ptr_legal = ({1'b0, new_off} < RAM_BYTES);
	wire logic [16:0] wr_end    = {1'b0, ptr_reg} + {9'h000, payload_length_reg};
	wire logic        wr_legal  = (wr_end <= RAM_BYTES);
	wire logic        wr_start  = is_ram_write && wr_legal && (payload_length_reg != 8'h00);

	// write stream into the buffer; the buffer's ready stalls the walk
	wire logic [15:0] wr_off    = ptr_reg + {8'h00, idx_reg};
	wire logic        push      = (state_reg == ST_WRITE) && !walk_end;
	wire logic        push_ok   = push && buf_in_ready;
	wire ram_write_type push_data = '{addr: RAM_BASE + {16'h0000, wr_off}, data: cur_byte};
	// ready is only flagged once every byte has left the buffer
	wire logic        write_done = (state_reg == ST_WRITE) && walk_end && !buf_out_valid;

	// completion events and the code each one reports
	// errors end the command early; a good write ends only once drained
	wire logic chk_fail = (state_reg == ST_CHECK) && (!known_cmd || !size_ok);
	wire logic sum_fail = (state_reg == ST_SUM) && walk_end && !frame_checksum_ok;
	wire logic exec_fin = (state_reg == ST_EXEC) && !is_reset && !wr_start;
	wire logic range_bad = (is_ptr_set && !ptr_legal) || (is_ram_write && !wr_legal);
	wire logic finish   = chk_fail || sum_fail || exec_fin || write_done;

	wire logic [7:0] exec_code = range_bad ? `STAT_RANGE_ERROR : `STAT_READY;
	wire logic [7:0] chk_code  = known_cmd ? `STAT_SIZE_ERROR : `STAT_UNSUPPORTED;
	wire logic [7:0] fin_code  =
		chk_fail ? chk_code :
		sum_fail ? `STAT_CHECKSUM_ERROR :
		exec_fin ? exec_code :
		`STAT_READY;

	// exec lasts one cycle, so each request below fires once per command
	wire logic exec_ok = (state_reg == ST_EXEC);

	// read data selection; the checksum slot wins over the data window
	wire logic [7:0] pwr_val  = pon_reg ? `PWR_CPU_READY : `PWR_STANDBY;
	wire logic       rd_data  = in_data && (data_off < payload_length_reg);
	wire logic       sel_cmd  = (req.addr == `OFS_COMMAND_STATUS);
	wire logic       sel_len  = (req.addr == `OFS_PAYLOAD_LENGTH);
	wire logic       sel_sum  = (req.addr == frame_checksum_pos);
	wire logic       sel_pwr  = (req.addr == `OFS_POWER_STATE);
	// unmapped addresses and data bytes past the length read as zero
	wire logic [7:0] read_val =
		sel_cmd ? command_status_reg :
		sel_len ? payload_length_reg :
		sel_sum ? frame_checksum_reg :
		rd_data ? data_mem[data_off[6:0]] :
		sel_pwr ? pwr_val :
		8'h00;

	// every output is driven straight from a register
	assign rdata         = rdata_reg;
	assign core_reset    = core_reset_reg;
	assign ram_remap     = remap_reg;
	assign download_init = download_init_reg;
	assign power_on      = pon_reg;
	assign ram_wr_valid  = buf_out_valid;
	assign ram_wr        = buf_out_data;

	// command sequencer: check takes one cycle, the sum walk one per data
	// byte plus one for the compare, exec one; a ram write then streams
	// through the buffer and returns to idle only once the buffer is empty,
	// so the ready code never shows while bytes are still in flight
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (trigger) begin
					state_next = ST_CHECK;
				end
			end
			ST_CHECK: begin
				state_next = chk_fail ? ST_IDLE : ST_SUM;
			end
			ST_SUM: begin
				if (walk_end) begin
					state_next = frame_checksum_ok ? ST_EXEC : ST_IDLE;
				end
			end
			ST_EXEC: begin
				state_next = wr_start ? ST_WRITE : ST_IDLE;
			end
			ST_WRITE: begin
				if (write_done) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// command byte: host code while idle, status code on completion
	// completion wins, though host frame writes are locked out while busy
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			command_status_reg <= `RST_COMMAND_STATUS;
		end else if (finish) begin
			command_status_reg <= fin_code;
		end else if (wr_cmd) begin
			command_status_reg <= req.wdata;
		end
	end

	// completion leaves a zero-length frame so readback shows status, 00, then the inverted status
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			payload_length_reg <= `RST_PAYLOAD_LENGTH;
		end else if (finish) begin
			payload_length_reg <= 8'h00;
		end else if (wr_len) begin
			payload_length_reg <= req.wdata;
		end
	end

	// checksum slot: host byte on the trigger write, inverted status on completion
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			frame_checksum_reg <= `RST_FRAME_CHECKSUM;
		end else if (finish) begin
			frame_checksum_reg <= fin_code ^ `CHECKSUM_INVERT;
		end else if (trigger) begin
			frame_checksum_reg <= req.wdata;
		end
	end

	// payload store, one byte register per entry
	// bytes past the length are kept but never summed or written
	for (genvar i = 0; i < 128; i++) begin : g_data
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				data_mem[i] <= 8'h00;
			end else if (data_wr && (data_off[6:0] == 7'(i))) begin
				data_mem[i] <= req.wdata;
			end
		end
	end

	// byte index: walks the data for the sum, then again for the ram write
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			idx_reg <= 8'h00;
		end else if (state_reg == ST_CHECK) begin
			idx_reg <= 8'h00;
		end else if ((state_reg == ST_SUM) && !walk_end) begin
			idx_reg <= idx_reg + 8'h01;
		end else if (exec_ok) begin
			idx_reg <= 8'h00;
		end else if (push_ok) begin
			idx_reg <= idx_reg + 8'h01;
		end
	end

	// running sum, seeded with the command and length bytes
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sum_reg <= 8'h00;
		end else if (state_reg == ST_CHECK) begin
			sum_reg <= command_status_reg + payload_length_reg;
		end else if ((state_reg == ST_SUM) && !walk_end) begin
			sum_reg <= sum_next;
		end
	end

	// RAM pointer offset; an illegal set or write leaves it alone
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ptr_reg <= 16'h0000;
		end else if (exec_ok && is_ptr_set && ptr_legal) begin
			ptr_reg <= new_off;
		end else if (write_done) begin
			ptr_reg <= wr_end[15:0];
		end
	end

	// remap bit survives the core reset it requests, so the restart
	// follows it; only the ROM map code or the device reset clears it
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			remap_reg <= 1'b0;
		end else if (exec_ok && is_ram_map) begin
			remap_reg <= 1'b1;
		end else if (exec_ok && is_rom_map) begin
			remap_reg <= 1'b0;
		end
	end

	// core reset request, one cycle; no status is written for reset codes
	// because the reset is meant to take the processor down at once
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			core_reset_reg <= 1'b0;
		end else begin
			core_reset_reg <= exec_ok && is_reset;
		end
	end

	// download hardware request, one cycle; the seed byte is summed but not
	// compared, so a frame with another seed still starts the hardware
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			download_init_reg <= 1'b0;
		end else begin
			download_init_reg <= exec_ok && is_dl_init;
		end
	end

	// power-state register, writable even while a command runs
	// standby reads as zero; there is no separate busy phase here
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pon_reg <= 1'b0;
		end else if (wr_pwr) begin
			pon_reg <= req.wdata[`PON_BIT];
		end
	end

	// registered read data, valid one cycle after the read strobe
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= 8'h00;
		end else if (req.rd) begin
			rdata_reg <= read_val;
		end
	end

	// the buffer absorbs RAM stalls so no byte of a write is dropped
	// a stalled word and the one behind it both stay parked in the buffer
	write_skid_buffer #(
		.WIDTH($bits(ram_write_type))
	) u_wbuf (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.in_valid  (push),
		.in_data   (push_data),
		.in_ready  (buf_in_ready),
		.out_valid (buf_out_valid),
		.out_data  (buf_out_data),
		.out_ready (ram_wr_ready)
	);

endmodule : boot_command_loader

`default_nettype wire

// >>> rtl/boot_loader_pkg.sv
// types shared by the boot command loader, its property checks and the bench models
package boot_loader_pkg;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_CHECK = 5'b00010,
		ST_SUM   = 5'b00100,
		ST_EXEC  = 5'b01000,
		ST_WRITE = 5'b10000
	} state_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

	typedef struct packed {
		logic [31:0] addr;
		logic [7:0]  data;
	} ram_write_type;

endpackage : boot_loader_pkg

// >>> rtl/boot_loader_regs.svh
// register offsets, codes, field values and reset values of the boot command loader
// Function
// - checksum is one's complement of low byte of command+size+all data bytes.
// - command codes lie in 0x10..0xFF; only defined codes are valid.
// - code 0x10, size 0, checksum 0xEF resets processor and digital core only.
// - software reset acts at once and leaves no completion status.
// - after reset, start from ROM or RAM according to the remap bit.
// - code 0x11, size 0, checksum 0xEE maps RAM to zero then resets.
// - code 0x12, size 0, checksum 0xED maps ROM to zero then resets.
// - download init is code 0x14, size 1, seed 0x29, checksum 0xC1; the seed itself is not compared.
// - RAM write is code 0x41, 0..0x80 data bytes, checksum right after.
// - a good RAM write leaves the pointer just past the written region.
// - a RAM write reaching outside RAM is skipped and reports out-of-range.
// - pointer set is code 0x43, size 2, low byte then high byte.
// - the RAM base address is added to the 16-bit pointer offset.
// - an illegal pointer location keeps the pointer and reports out-of-range.
// - a malformed command is not executed and reports an error code.
// - a good RAM write or pointer set writes the ready code.
// - status codes: ready 0, size 1, checksum 2, unsupported 3, range 7.
// - a reset-type command with nonzero size gets the size error.
// - power-state register reads 0x41 when the processor is ready.
`ifndef BOOT_LOADER_REGS_SVH
`define BOOT_LOADER_REGS_SVH

`define OFS_COMMAND_STATUS 8'h08
`define OFS_PAYLOAD_LENGTH 8'h09
`define OFS_PAYLOAD_BYTE   8'h0a
`define OFS_POWER_STATE    8'he0

`define RST_COMMAND_STATUS 8'h00
`define RST_PAYLOAD_LENGTH 8'h00
`define RST_FRAME_CHECKSUM 8'hff

`define CMD_SYS_RESET      8'h10
`define CMD_RAM_MAP_REBOOT 8'h11
`define CMD_ROM_MAP_REBOOT 8'h12
`define CMD_DOWNLOAD_INIT  8'h14
`define CMD_RAM_WRITE      8'h41
`define CMD_POINTER_SET    8'h43

`define STAT_READY          8'h00
`define STAT_SIZE_ERROR     8'h01
`define STAT_CHECKSUM_ERROR 8'h02
`define STAT_UNSUPPORTED    8'h03
`define STAT_RANGE_ERROR    8'h07

`define CHECKSUM_INVERT 8'hff
`define MAX_PAYLOAD     8'h80
`define SIZE_DL_INIT    8'h01
`define SIZE_POINTER    8'h02
`define PWR_CPU_READY   8'h41
`define PWR_STANDBY     8'h00
`define PON_BIT         0

`endif

// >>> rtl/write_skid_buffer.sv
// two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ps
`default_nettype none

module write_skid_buffer #(
	parameter int WIDTH = 40
) (
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);

	logic             skid_valid_reg;
	logic [WIDTH-1:0] skid_data_reg;
	logic             out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;

	// the output slot may take new data when empty or being drained
	wire logic out_free = out_ready || !out_valid_reg;
	wire logic in_take  = in_valid && !skid_valid_reg;

	assign in_ready  = !skid_valid_reg;
	assign out_valid = out_valid_reg;
	assign out_data  = out_data_reg;

	// output slot: the skid entry has priority to keep word order
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
		end else if (out_free) begin
			out_valid_reg <= skid_valid_reg || in_valid;
			out_data_reg  <= skid_valid_reg ? skid_data_reg : in_data;
		end
	end

	// skid slot catches a word taken while the output stalls
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			skid_valid_reg <= 1'b0;
			skid_data_reg  <= '0;
		end else if (out_free) begin
			skid_valid_reg <= 1'b0;
		end else if (in_take) begin
			skid_valid_reg <= 1'b1;
			skid_data_reg  <= in_data;
		end
	end

endmodule : write_skid_buffer

`default_nettype wire

// >>> verif/boot_command_loader_props.sv
// concurrent checks on the boot command loader ports
`timescale 1ns/1ps
`default_nettype none

module boot_command_loader_props
	import boot_loader_pkg::*;
#(
	parameter logic [31:0] RAM_BASE  = 32'h2000_0000,
	parameter logic [16:0] RAM_BYTES = 17'h0_4000
) (
	input wire logic          mclk,
	input wire logic          arst_n,
	input wire reg_req_type   req,
	input wire logic [7:0]    rdata,
	input wire logic          core_reset,
	input wire logic          ram_remap,
	input wire logic          download_init,
	input wire logic          power_on,
	input wire logic          ram_wr_valid,
	input wire ram_write_type ram_wr,
	input wire logic          ram_wr_ready
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	chk_word_held: assert property (ram_wr_valid && !ram_wr_ready |=>
		ram_wr_valid && $stable(ram_wr))
		else $error("ram word dropped while stalled");
	chk_reset_pulse: assert property (core_reset |=> !core_reset)
		else $error("core reset longer than one cycle");
	chk_init_pulse: assert property (download_init |=> !download_init)
		else $error("download init longer than one cycle");
	chk_remap_kept: assert property (ram_remap |=> ram_remap)
		else $error("remap bit lost without reset");
	chk_remap_reboot: assert property ($rose(ram_remap) |-> ##[0:2] core_reset)
		else $error("ram remap without core reset");
	chk_pon_write: assert property (req.wr && req.addr == 8'he0 |=>
		power_on == $past(req.wdata[0]))
		else $error("power bit not taken from write");
	chk_pon_read: assert property (req.rd && req.addr == 8'he0 |->
		##2 rdata == ($past(power_on, 2) ? 8'h41 : 8'h00))
		else $error("power state read wrong");
	chk_ram_range: assert property (ram_wr_valid |->
		ram_wr.addr - RAM_BASE < {15'h0, RAM_BYTES})
		else $error("ram write outside ram");
	chk_ram_base: assert property (ram_wr_valid |-> ram_wr.addr >= RAM_BASE)
		else $error("ram write below the ram base");
	chk_rdata_hold: assert property (!req.rd && !$past(req.rd) |=> $stable(rdata))
		else $error("read data changed without read");
endmodule : boot_command_loader_props

bind boot_command_loader boot_command_loader_props #(.RAM_BASE(RAM_BASE), .RAM_BYTES(RAM_BYTES))
	i_props (.mclk, .arst_n, .req, .rdata, .core_reset, .ram_remap, .download_init, .power_on,
	.ram_wr_valid, .ram_wr, .ram_wr_ready);

`default_nettype wire

// >>> verif/boot_command_loader_tb.sv
// self-checking bench for the boot command loader
`timescale 1ns/1ps
`default_nettype none

module boot_command_loader_tb
	import boot_loader_pkg::*;
;
	typedef struct packed { logic [7:0] cmd, size, d0, d1, bad, exp; } row_type;
	logic          mclk = 1'b0;
	logic          arst_n = 1'b0;
	logic          slow = 1'b0;
	reg_req_type   req = '0;
	logic [7:0]    rdata, v;
	logic          core_reset, ram_remap, download_init, power_on, ram_wr_valid, ram_wr_ready;
	ram_write_type ram_wr;
	logic [7:0]    q [$];
	int            n_mismatch = 0;
	int            n_checks = 0;
	int            k;
	int            n_init = 0;
	// frames: command, length, data, corrupt checksum, expected status
	row_type rows [11] = '{
		'{8'h14, 8'h01, 8'h29, 8'h00, 8'h0, 8'h00}, '{8'h43, 8'h02, 8'h00, 8'h00, 8'h0, 8'h00},
		'{8'h41, 8'h02, 8'ha5, 8'h5a, 8'h0, 8'h00}, '{8'h41, 8'h02, 8'hc3, 8'h3c, 8'h0, 8'h00},
		'{8'h43, 8'h02, 8'h00, 8'h40, 8'h0, 8'h07}, '{8'h41, 8'h01, 8'h77, 8'h00, 8'h0, 8'h00},
		'{8'h41, 8'h02, 8'h11, 8'h22, 8'h1, 8'h02}, '{8'h10, 8'h01, 8'h00, 8'h00, 8'h0, 8'h01},
		'{8'h20, 8'h00, 8'h00, 8'h00, 8'h0, 8'h03}, '{8'h43, 8'h02, 8'hff, 8'h3f, 8'h0, 8'h00},
		'{8'h41, 8'h02, 8'h01, 8'h02, 8'h0, 8'h07}};

	boot_command_loader i_boot_command_loader (.mclk, .arst_n, .req, .rdata, .core_reset,
		.ram_remap, .download_init, .power_on, .ram_wr_valid, .ram_wr, .ram_wr_ready);
	ram_sink_model i_ram_sink_model (.mclk, .arst_n, .slow, .ram_wr_valid, .ram_wr, .ram_wr_ready);

	initial begin
		forever #4 mclk = ~mclk;
	end

	// count download requests mid-cycle, where the one-cycle pulse stands
	always @(negedge mclk) begin
		if (download_init === 1'b1) n_init++;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// strobes rise and fall on falling edges with an idle cycle between
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		req = '{1'b1, 1'b0, a, d};
		@(negedge mclk);
		req = '0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(negedge mclk);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge mclk);
		req = '0;
		@(negedge mclk);
		v = rdata;
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk($sformatf("reg %h", a), v, exp);
	endtask : rc

	// sends q from the command slot on, then the checksum that starts it
	task automatic send(input logic bad);
		logic [7:0] s;
		s = 8'h00;
		foreach (q[i]) begin
			wr(8'h08 + 8'(i), q[i]);
			s += q[i];
		end
		wr(8'h08 + 8'(q.size()), ~s ^ {7'h00, bad});
	endtask : send

	// poll the status byte; a hang counts as a mismatch
	task automatic wait_idle();
		k = 0;
		rd(8'h08);
		while (v >= 8'h10 && k < 400) begin
			rd(8'h08);
			k++;
		end
		if (v >= 8'h10) begin
			n_mismatch++;
			results();
		end
	endtask : wait_idle

	initial begin
		repeat (3) @(negedge mclk);
		arst_n = 1'b1;
		rc(8'h08, 8'h00);
		rc(8'h09, 8'h00);
		rc(8'h0a, 8'hff);
		rc(8'he0, 8'h00);
		wr(8'he0, 8'h01);
		rc(8'he0, 8'h41);
		foreach (rows[i]) begin
			q = {rows[i].cmd, rows[i].size};
			if (rows[i].size > 0) q.push_back(rows[i].d0);
			if (rows[i].size > 1) q.push_back(rows[i].d1);
			send(rows[i].bad[0]);
			wait_idle();
			chk("status", v, rows[i].exp);
			if (rows[i].exp == 8'h00) begin
				rc(8'h09, 8'h00);
				rc(8'h0a, 8'hff);
			end
		end
		chk("init pulses", 8'(n_init), 8'h01);
		chk("ram 0", i_ram_sink_model.mem[0], 8'ha5);
		chk("ram 3", i_ram_sink_model.mem[3], 8'h3c);
		chk("ram 4", i_ram_sink_model.mem[4], 8'h77);
		// full-size write at offset 0x10 into a stalling sink, then one more byte
		q = {8'h43, 8'h02, 8'h10, 8'h00};
		send(1'b0);
		wait_idle();
		slow = 1'b1;
		q = {8'h41, 8'h80};
		for (int i = 0; i < 128; i++) q.push_back(8'(i));
		send(1'b0);
		wait_idle();
		q = {8'h41, 8'h01, 8'h5e};
		send(1'b0);
		wait_idle();
		for (int i = 0; i < 128; i++) chk("ram", i_ram_sink_model.mem[16 + i], 8'(i));
		chk("ram 90", i_ram_sink_model.mem[8'h90], 8'h5e);
		// each reboot code pulses core reset and leaves its code pending
		for (int c = 16; c <= 18; c++) begin
			arst_n = 1'b0;
			@(negedge mclk);
			arst_n = 1'b1;
			wr(8'he0, 8'h01);
			q = {8'(c), 8'h00};
			send(1'b0);
			k = 0;
			while (core_reset !== 1'b1 && k < 50) begin
				@(negedge mclk);
				k++;
			end
			if (core_reset !== 1'b1) begin
				n_mismatch++;
				results();
			end
			chk("core_reset", {7'h0, core_reset}, 8'h01);
			chk("remap", {7'h0, ram_remap}, {7'h0, c == 17});
			rc(8'h08, 8'(c));
			rc(8'he0, 8'h41);
		end
		results();
	end
endmodule : boot_command_loader_tb

`default_nettype wire

// >>> verif/ram_sink_model.sv
// ram sink on the loader write path, prompt or slow acceptance
`timescale 1ns/1ps
`default_nettype none

module ram_sink_model
	import boot_loader_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          arst_n,
	input  wire logic          slow,
	input  wire logic          ram_wr_valid,
	input  wire ram_write_type ram_wr,
	output logic               ram_wr_ready
);
	logic [7:0] mem [0:255];
	logic [1:0] tick_reg;

	// slow mode takes one cycle in four so the buffer fills and refuses
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tick_reg     <= 2'h0;
			ram_wr_ready <= 1'b0;
		end else begin
			tick_reg     <= tick_reg + 2'h1;
			ram_wr_ready <= !slow || (tick_reg == 2'h3);
		end
	end

	// keep accepted bytes by low address byte, enough for short patches
	always_ff @(posedge mclk) begin
		if (ram_wr_valid && ram_wr_ready) begin
			mem[ram_wr.addr[7:0]] <= ram_wr.data;
		end
	end
endmodule : ram_sink_model

`default_nettype wire
